/* byte_move_instruction_exec.sv */
// Byte move executor: fetches, decodes and runs the byte data-transfer instructions
// How it works
// - Eight 32-bit registers, used whole or by the two bytes of the lower half.
// - Each byte move sets N and Z from the byte, clears V, keeps C.
// - Post-increment load reads at the wide register, then adds one; two bytes long.
// - Pre-decrement store subtracts one first, then writes there; two bytes long.
// - Store with 16-bit displacement is four bytes, writes at base plus displacement.
// - Store with 24-bit displacement is eight bytes, writes at base plus displacement.
`include "byte_move_map.svh"

module byte_move_instruction_exec (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Instruction fetch, 16-bit words
    output logic o_fetch_req,
    output logic [31:0] o_fetch_addr,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_data,
    // Data memory, byte wide
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    // Status
    output logic [7:0] o_condition_code_reg,
    output logic o_retire,
    input wire byte_move_pkg::wide_sel_t i_dbg_sel,
    output logic [31:0] o_dbg_reg
);
    import byte_move_pkg::*;

    exec_state_t state;
    exec_state_t next_state;
    logic [31:0] pc;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    logic [1:0] ext_left;
    logic [1:0] ext_idx;
    logic [7:0] condition_code_reg;
    logic retire;

    // Decoded fields
    wire logic [3:0] op = w0[`F_OP_HI:`F_OP_LO];
    wire logic [3:0] first_op = i_fetch_data[`F_OP_HI:`F_OP_LO];
    wire byte_sel_t byte_reg = w0[`F_BYTE_HI:`F_BYTE_LO];
    wire byte_sel_t byte_source_reg = w0[`F_SRC_HI:`F_SRC_LO];
    wire wide_sel_t wide_reg = w0[`F_WIDE_HI:`F_WIDE_LO];

    // Extension words following the first word, by operation
    function automatic logic [1:0] ext_words(input logic [3:0] code);
        unique case (code)
            `OP_LD_D16, `OP_ST_D16, `OP_LD_AA16, `OP_ST_AA16: ext_words = 2'd1;
            `OP_LD_AA24, `OP_ST_AA24: ext_words = 2'd2;
            `OP_LD_D24, `OP_ST_D24: ext_words = 2'd3;
            default: ext_words = 2'd0;
        endcase
    endfunction : ext_words

    wire logic is_store = op[3] && (op != `OP_LD_AA24);
    wire logic is_load = !is_store && (op != `OP_IMM) && (op != `OP_REG);
    wire logic is_mem = is_load || is_store;
    wire logic is_inc = (op == `OP_LD_INC);
    wire logic is_dec = (op == `OP_ST_DEC);

    // Register file hookup
    logic [7:0] byte_a;
    logic [7:0] byte_b;
    logic [31:0] wide_dest_reg;

    wire logic in_exec = (state == ST_EXEC);
    wire logic mem_done = (state == ST_MEM) && i_mem_ack;
    wire logic load_done = mem_done && !o_mem_we;
    wire logic store_done = mem_done && o_mem_we;

    wire logic [31:0] disp16 = {{16{w1[15]}}, w1};
    wire logic [31:0] disp24 = {{8{w2[7]}}, w2[7:0], w3};
    wire logic [31:0] wide_minus = wide_dest_reg - `ADDR_ONE;
    wire logic [31:0] wide_plus = wide_dest_reg + `ADDR_ONE;

    // Effective address, worked out once in the execute cycle
    logic [31:0] eff_addr;
    always_comb begin
        unique case (op)
            `OP_LD_D16, `OP_ST_D16: eff_addr = wide_dest_reg + disp16;
            `OP_LD_D24, `OP_ST_D24: eff_addr = wide_dest_reg + disp24;
            `OP_ST_DEC: eff_addr = wide_minus;
            `OP_LD_AA8, `OP_ST_AA8: eff_addr = {`AA8_HIGH, w0[7:0]};
            `OP_LD_AA16, `OP_ST_AA16: eff_addr = disp16;
            `OP_LD_AA24, `OP_ST_AA24: eff_addr = {8'h00, w1[7:0], w2};
            default: eff_addr = wide_dest_reg;
        endcase
    end

    // Byte and wide writes
    // Byte write lands after the wide one, so a load into its own pointer keeps the byte
    wire logic byte_we = (in_exec && !is_mem) || load_done;
    wire logic [7:0] byte_data = load_done ? i_mem_rdata :
        (op == `OP_IMM) ? w0[7:0] : byte_b;
    wire logic wide_we = (in_exec && is_dec) || (load_done && is_inc);
    wire logic [31:0] wide_data = in_exec ? wide_minus : wide_plus;

    byte_move_regfile #(
        .NUM_WIDE(8)
    ) u_regs (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_rd_a_sel(byte_reg),
        .o_rd_a(byte_a),
        .i_rd_b_sel(byte_source_reg),
        .o_rd_b(byte_b),
        .i_wide_sel(wide_reg),
        .o_wide(wide_dest_reg),
        .i_dbg_sel(i_dbg_sel),
        .o_dbg(o_dbg_reg),
        .i_byte_we(byte_we),
        .i_byte_sel(byte_reg),
        .i_byte_data(byte_data),
        .i_wide_we(wide_we),
        .i_wide_wsel(wide_reg),
        .i_wide_data(wide_data)
    );

    // Flags follow the byte that moved
    // Carry is never written, so it keeps its reset value
    wire logic flag_upd = byte_we || store_done;
    wire logic [7:0] flag_byte = store_done ? o_mem_wdata : byte_data;
    logic [7:0] next_ccr;
    always_comb begin
        next_ccr = condition_code_reg;
        if (flag_upd) begin
            next_ccr[`CC_N] = flag_byte[7];
            next_ccr[`CC_Z] = (flag_byte == 8'h00);
            next_ccr[`CC_V] = 1'b0;
        end
    end

    // Sequencer
    wire logic fetch_take = (state == ST_FETCH || state == ST_EXT) && i_fetch_valid;
    wire logic first_take = fetch_take && (state == ST_FETCH);
    wire logic ext_take = fetch_take && (state == ST_EXT);
    wire logic [1:0] first_ext = ext_words(first_op);
    always_comb begin
        next_state = state;
        unique case (state)
            ST_FETCH: if (i_fetch_valid) begin
                next_state = (first_ext == 2'd0) ? ST_EXEC : ST_EXT;
            end
            ST_EXT: if (i_fetch_valid && ext_left == 2'd1) begin
                next_state = ST_EXEC;
            end
            ST_EXEC: next_state = is_mem ? ST_MEM : ST_FETCH;
            ST_MEM: if (i_mem_ack) begin
                next_state = ST_FETCH;
            end
        endcase
    end

    assign o_fetch_req = (state == ST_FETCH) || (state == ST_EXT);
    assign o_mem_req = (state == ST_MEM);
    assign o_fetch_addr = pc;
    assign o_condition_code_reg = condition_code_reg;
    assign o_retire = retire;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_FETCH;
            pc <= `PC_RESET;
            condition_code_reg <= `CC_RESET;
            retire <= 1'b0;
        end else begin
            state <= next_state;
            condition_code_reg <= next_ccr;
            retire <= flag_upd;
            if (fetch_take) begin
                pc <= pc + `PC_STEP;
            end
        end
    end

    // Instruction words; unused extension words simply keep stale data
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            w0 <= 16'h0000;
            w1 <= 16'h0000;
            w2 <= 16'h0000;
            w3 <= 16'h0000;
            ext_left <= 2'd0;
            ext_idx <= 2'd0;
        end else if (first_take) begin
            w0 <= i_fetch_data;
            ext_left <= first_ext;
            ext_idx <= 2'd1;
        end else if (ext_take) begin
            ext_left <= ext_left - 2'd1;
            ext_idx <= ext_idx + 2'd1;
            w1 <= (ext_idx == 2'd1) ? i_fetch_data : w1;
            w2 <= (ext_idx == 2'd2) ? i_fetch_data : w2;
            w3 <= (ext_idx == 2'd3) ? i_fetch_data : w3;
        end
    end

    // Data access latched at execute so the bus sees stable values
    // The store byte is read before a pre-decrement reaches the register file
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_we <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_wdata <= 8'h00;
        end else if (in_exec && is_mem) begin
            o_mem_we <= is_store;
            o_mem_addr <= eff_addr;
            o_mem_wdata <= byte_a;
        end
    end

endmodule : byte_move_instruction_exec

/* byte_move_map.svh */
// Constants for the byte move executor: encodings, flag positions, reset values
`ifndef BYTE_MOVE_MAP_SVH
`define BYTE_MOVE_MAP_SVH

// Operation codes in bits 15:12 of the first instruction word
`define OP_IMM 4'h0
`define OP_REG 4'h1
`define OP_LD_IND 4'h2
`define OP_LD_D16 4'h3
`define OP_LD_D24 4'h4
`define OP_LD_INC 4'h5
`define OP_LD_AA8 4'h6
`define OP_LD_AA16 4'h7
`define OP_LD_AA24 4'h8
`define OP_ST_IND 4'h9
`define OP_ST_D16 4'hA
`define OP_ST_D24 4'hB
`define OP_ST_DEC 4'hC
`define OP_ST_AA8 4'hD
`define OP_ST_AA16 4'hE
`define OP_ST_AA24 4'hF

// Field positions of the first instruction word
`define F_OP_HI 15
`define F_OP_LO 12
`define F_BYTE_HI 11
`define F_BYTE_LO 8
`define F_SRC_HI 7
`define F_SRC_LO 4
`define F_WIDE_HI 6
`define F_WIDE_LO 4

// Byte register select: bit 3 set picks the low byte, bits 2:0 the wide register
`define BSEL_LOW_BIT 3

// Condition code bit positions and reset value
`define CC_N 3
`define CC_Z 2
`define CC_V 1
`define CC_C 0
`define CC_RESET 8'h00

// Short absolute addresses live in the top 256 bytes
`define AA8_HIGH 24'hFFFFFF
`define PC_RESET 32'h0000_0000
`define PC_STEP 32'h0000_0002
`define ADDR_ONE 32'h0000_0001

`endif

/* byte_move_pkg.sv */
// Types shared by the byte move executor
package byte_move_pkg;

    typedef enum logic [3:0] {
        ST_FETCH = 4'b0001,
        ST_EXT = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_MEM = 4'b1000
    } exec_state_t;

    typedef logic [3:0] byte_sel_t;
    typedef logic [2:0] wide_sel_t;

endpackage : byte_move_pkg

/* byte_move_regfile.sv */
// General register file: eight wide registers with byte and wide access
`include "byte_move_map.svh"

module byte_move_regfile #(
    parameter int NUM_WIDE = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Byte read ports
    input wire byte_move_pkg::byte_sel_t i_rd_a_sel,
    output logic [7:0] o_rd_a,
    input wire byte_move_pkg::byte_sel_t i_rd_b_sel,
    output logic [7:0] o_rd_b,
    // Wide read ports
    input wire byte_move_pkg::wide_sel_t i_wide_sel,
    output logic [31:0] o_wide,
    input wire byte_move_pkg::wide_sel_t i_dbg_sel,
    output logic [31:0] o_dbg,
    // Write ports; byte write lands after the wide write
    input wire logic i_byte_we,
    input wire byte_move_pkg::byte_sel_t i_byte_sel,
    input wire logic [7:0] i_byte_data,
    input wire logic i_wide_we,
    input wire byte_move_pkg::wide_sel_t i_wide_wsel,
    input wire logic [31:0] i_wide_data
);
    import byte_move_pkg::*;

    if (NUM_WIDE != 8) begin : g_bad_count
        $error("byte select encoding serves exactly eight wide registers");
    end

    logic [31:0] regs [NUM_WIDE];

    function automatic logic [7:0] pick(input logic [31:0] w, input logic low);
        pick = low ? w[7:0] : w[15:8];
    endfunction : pick

    assign o_rd_a = pick(regs[i_rd_a_sel[2:0]], i_rd_a_sel[`BSEL_LOW_BIT]);
    assign o_rd_b = pick(regs[i_rd_b_sel[2:0]], i_rd_b_sel[`BSEL_LOW_BIT]);
    assign o_wide = regs[i_wide_sel];
    assign o_dbg = regs[i_dbg_sel];

    for (genvar g = 0; g < NUM_WIDE; g++) begin : g_reg
        wire logic hit_w = i_wide_we && (i_wide_wsel == 3'(g));
        wire logic hit_b = i_byte_we && (i_byte_sel[2:0] == 3'(g));
        wire logic [31:0] after_w = hit_w ? i_wide_data : regs[g];
        wire logic [31:0] after_b = !hit_b ? after_w :
            i_byte_sel[`BSEL_LOW_BIT] ? {after_w[31:8], i_byte_data} :
            {after_w[31:16], i_byte_data, after_w[7:0]};
        always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
                regs[g] <= 32'h0000_0000;
            end else begin
                regs[g] <= after_b;
            end
        end
    end

endmodule : byte_move_regfile

/* byte_move_instruction_exec_monitor.sv */
// Port checker for the byte move executor
module byte_move_instruction_exec_monitor (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Buses
    input wire logic o_fetch_req,
    input wire logic [31:0] o_fetch_addr,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_data,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire logic [31:0] o_mem_addr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    // Status
    input wire logic [7:0] o_condition_code_reg,
    input wire logic o_retire
);
    logic [2:0] wc;
    logic [3:0] op;
    wire take = o_fetch_req && i_fetch_valid;
    wire [2:0] len = (op == 4'h4 || op == 4'hB) ? 3'h4 : (op == 4'h8 || op == 4'hF) ? 3'h3 :
        (op == 4'h3 || op == 4'h7 || op == 4'hA || op == 4'hE) ? 3'h2 : 3'h1;
    wire [7:0] cc = o_condition_code_reg;

    // Words taken per instruction; a take in the retire cycle opens the next one
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wc <= 3'h0;
            op <= 4'h0;
        end else begin
            wc <= (o_retire ? 3'h0 : wc) + {2'h0, take};
            if (take && (o_retire || wc == 3'h0)) op <= i_fetch_data[15:12];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_load_done; o_mem_req && i_mem_ack && !o_mem_we; endsequence
    sequence s_store_done; o_mem_req && i_mem_ack && o_mem_we; endsequence

    property p_len; o_retire |-> wc == len; endproperty
    a_len: assert property (p_len)
        else $error("instruction length wrong");
    property p_load_cc;
        s_load_done |=> o_retire &&
            cc[3:1] == {$past(i_mem_rdata[7]), $past(i_mem_rdata) == 8'h00, 1'b0};
    endproperty
    a_load_cc: assert property (p_load_cc)
        else $error("load flags wrong");
    property p_store_cc;
        s_store_done |=> o_retire &&
            cc[3:1] == {$past(o_mem_wdata[7]), $past(o_mem_wdata) == 8'h00, 1'b0};
    endproperty
    a_store_cc: assert property (p_store_cc)
        else $error("store flags wrong");
    property p_c_keep; $stable(cc[0]); endproperty
    a_c_keep: assert property (p_c_keep)
        else $error("carry changed");
    property p_cc_retire; $changed(cc) |-> o_retire; endproperty
    a_cc_retire: assert property (p_cc_retire)
        else $error("flags changed off retire");
    property p_mem_hold;
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) &&
            $stable(o_mem_we) && $stable(o_mem_wdata);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("access dropped early");
    property p_fetch_step; take |=> o_fetch_addr == $past(o_fetch_addr) + 32'h2; endproperty
    a_fetch_step: assert property (p_fetch_step)
        else $error("fetch address step wrong");
    property p_retire_pulse; o_retire |=> !o_retire; endproperty
    a_retire_pulse: assert property (p_retire_pulse)
        else $error("retire too long");
endmodule : byte_move_instruction_exec_monitor

bind byte_move_instruction_exec byte_move_instruction_exec_monitor u_mon (.*);

/* byte_move_mem_model.sv */
// Program and data memory answering with random stalls
module byte_move_mem_model (
    // Clock
    input wire logic i_clk_sys,
    // Fetch
    input wire logic i_fetch_req,
    input wire logic [31:0] i_fetch_addr,
    output logic o_fetch_valid,
    output logic [15:0] o_fetch_data,
    // Data
    input wire logic i_mem_req,
    input wire logic i_mem_we,
    input wire logic [31:0] i_mem_addr,
    input wire logic [7:0] i_mem_wdata,
    output logic o_mem_ack,
    output logic [7:0] o_mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] prog [256];
    logic [7:0] mem [256];
    initial begin
        {o_fetch_valid, o_mem_ack, o_fetch_data, o_mem_rdata} = 26'h0;
        foreach (mem[i]) mem[i] = 8'(i * 7 + 3);
        foreach (prog[i]) prog[i] = 16'h0000;
    end
    // Data lines flip when not valid so stale values never pass
    always @(posedge i_clk_sys) begin
        if (i_mem_req && o_mem_ack && i_mem_we) mem[i_mem_addr[7:0]] = i_mem_wdata;
        #1;
        o_fetch_valid = i_fetch_req && $urandom_range(3) != 0;
        o_fetch_data = o_fetch_valid ? prog[i_fetch_addr[8:1]] : ~o_fetch_data;
        o_mem_ack = i_mem_req && $urandom_range(2) != 0;
        o_mem_rdata = (o_mem_ack && !i_mem_we) ? mem[i_mem_addr[7:0]] : ~o_mem_rdata;
    end
endmodule : byte_move_mem_model

/* byte_move_instruction_exec_tb_top.sv */
// Bench comparing the byte move executor with a queue based model
module byte_move_instruction_exec_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import byte_move_pkg::*;
    logic i_clk_sys = 1'b0, i_rst_n = 1'b0;
    logic o_fetch_req, i_fetch_valid, o_mem_req, o_mem_we, i_mem_ack, o_retire;
    logic [31:0] o_fetch_addr, o_mem_addr, o_dbg_reg;
    logic [15:0] i_fetch_data;
    logic [7:0] o_mem_wdata, i_mem_rdata, o_condition_code_reg;
    wide_sel_t i_dbg_sel = 3'h0;
    logic [31:0] rf [8];
    logic [7:0] mm [256];
    logic [7:0] cc = 8'h00;
    logic [40:0] q_acc [$], q_reg [$];
    wide_sel_t q_sel [$];
    int pc, n_ret, cyc, fail_count, checked;
    wire [40:0] acc_seen = {o_mem_we, o_mem_addr, o_mem_we ? o_mem_wdata : i_mem_rdata};
    wire [40:0] reg_seen = {1'b0, o_condition_code_reg, o_dbg_reg};

    always #2 i_clk_sys = ~i_clk_sys;
    byte_move_instruction_exec u_byte_move_instruction_exec (.*);
    byte_move_mem_model u_byte_move_mem_model (.i_clk_sys(i_clk_sys),
        .i_fetch_req(o_fetch_req), .i_fetch_addr(o_fetch_addr), .o_fetch_valid(i_fetch_valid),
        .o_fetch_data(i_fetch_data), .i_mem_req(o_mem_req), .i_mem_we(o_mem_we),
        .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_ack(i_mem_ack),
        .o_mem_rdata(i_mem_rdata));

    task automatic chk(input string nm, input logic [40:0] e, s);
        checked++;
        if (e !== s) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    function automatic logic [7:0] rd_b(input logic [3:0] b);
        return b[3] ? rf[b[2:0]][7:0] : rf[b[2:0]][15:8];
    endfunction : rd_b

    // Model one instruction and place its words in program memory
    task automatic emit(input logic [3:0] op, b, input logic [7:0] lo,
        input logic [15:0] w1, w2, w3);
        logic [31:0] a;
        logic [7:0] v;
        wide_sel_t w;
        int n;
        logic [15:0] ext [3];
        w = lo[6:4];
        a = rf[w];
        ext = '{w1, w2, w3};
        n = (op == 4'h4 || op == 4'hB) ? 4 : (op == 4'h8 || op == 4'hF) ? 3 :
            (op == 4'h3 || op == 4'h7 || op == 4'hA || op == 4'hE) ? 2 : 1;
        for (int i = 0; i < n; i++) begin
            u_byte_move_mem_model.prog[pc + i] = i ? ext[i - 1] : {op, b, lo};
        end
        pc += n;
        if (op == 4'h3 || op == 4'hA) a = a + {{16{w1[15]}}, w1};
        if (op == 4'h4 || op == 4'hB) a = a + {{8{w2[7]}}, w2[7:0], w3};
        if (op == 4'hC) a = a - 32'h1;
        if (op == 4'h6 || op == 4'hD) a = {24'hFFFFFF, lo};
        if (op == 4'h7 || op == 4'hE) a = {{16{w1[15]}}, w1};
        if (op == 4'h8 || op == 4'hF) a = {8'h00, w1[7:0], w2};
        v = (op == 4'h0) ? lo : (op == 4'h1) ? rd_b(lo[7:4]) : (op < 4'h9) ? mm[a[7:0]] : rd_b(b);
        if (op == 4'h5) rf[w] = a + 32'h1;
        if (op == 4'hC) rf[w] = a;
        if (op < 4'h9 && b[3]) rf[b[2:0]][7:0] = v;
        if (op < 4'h9 && !b[3]) rf[b[2:0]][15:8] = v;
        if (op > 4'h8) mm[a[7:0]] = v;
        if (op > 4'h1) q_acc.push_back({op > 4'h8, a, v});
        cc = {4'h0, v[7], v == 8'h00, 1'b0, cc[0]};
        w = (op < 4'h9) ? b[2:0] : w;
        q_sel.push_back(w);
        q_reg.push_back({1'b0, cc, rf[w]});
    endtask : emit

    task automatic give_verdict;
        $display("Counts: checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // Outputs settle by the falling edge
    always @(negedge i_clk_sys) begin
        if (i_rst_n && o_mem_req && i_mem_ack) begin
            chk("access", q_acc.pop_front(), acc_seen);
        end
        if (i_rst_n && o_retire) begin
            chk("flags_reg", q_reg.pop_front(), reg_seen);
            void'(q_sel.pop_front());
            n_ret++;
        end
    end
    always @(posedge i_clk_sys) #1 i_dbg_sel = q_sel.size() ? q_sel[0] : 3'h0;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            $display("Timeout at cycle %0d", cyc);
            give_verdict();
        end
    end

    initial begin
        // Let the memory model clear its program before it is filled
        #1;
        void'($urandom(19));
        pc = 0;
        foreach (rf[i]) rf[i] = 32'h0;
        foreach (mm[i]) mm[i] = 8'(i * 7 + 3);
        emit(4'h0, 4'h9, 8'h80, 0, 0, 0);
        emit(4'h0, 4'h1, 8'h00, 0, 0, 0);
        emit(4'h0, 4'h1, 8'h5A, 0, 0, 0);
        emit(4'h5, 4'h9, 8'h10, 0, 0, 0);
        emit(4'hC, 4'h1, 8'h10, 0, 0, 0);
        emit(4'hA, 4'h9, 8'h10, 16'hFFFE, 0, 0);
        emit(4'hB, 4'h1, 8'h10, 16'hFFFF, 16'h00FF, 16'hFFF0);
        emit(4'h1, 4'h8, 8'h10, 0, 0, 0);
        emit(4'h2, 4'h0, 8'h10, 0, 0, 0);
        emit(4'h9, 4'h8, 8'h10, 0, 0, 0);
        repeat (40) emit(4'($urandom), 4'($urandom), 8'($urandom), 16'($urandom),
            16'($urandom), 16'($urandom));
        repeat (8) @(posedge i_clk_sys);
        #1;
        chk("reset", 41'h0, {1'b0, o_fetch_addr, o_condition_code_reg});
        chk("rst_bus", 41'h1, {o_mem_req, o_retire, o_mem_addr, 6'h0, o_fetch_req});
        i_rst_n = 1'b1;
        while (n_ret < 10) @(posedge i_clk_sys);
        $display("Directed test done, %0d retired", n_ret);
        while (n_ret < 50) @(posedge i_clk_sys);
        $display("Random test done, %0d retired", n_ret);
        chk("leftover", 41'h0, 41'(q_acc.size() + q_reg.size()));
        give_verdict();
    end
endmodule : byte_move_instruction_exec_tb_top
